// *** include/fsv_pkg.sv ***
package fsv_pkg;

    // Command opcodes
    localparam logic [7:0] OP_WRR    = 8'h01;
    localparam logic [7:0] OP_PP     = 8'h02;
    localparam logic [7:0] OP_WRITE_FORBID_CMD   = 8'h04;
    localparam logic [7:0] OP_READ_STATUS_ONE_CMD  = 8'h05;
    localparam logic [7:0] OP_WRITE_PERMIT_CMD   = 8'h06;
    localparam logic [7:0] OP_READ_STATUS_TWO_CMD  = 8'h07;
    localparam logic [7:0] OP_CLEAR_STATUS_CMD_A = 8'h30;
    localparam logic [7:0] OP_CLEAR_STATUS_CMD_B = 8'h82;
    localparam logic [7:0] OP_OTPP   = 8'h42;
    localparam logic [7:0] OP_BE_A   = 8'h60;
    localparam logic [7:0] OP_BE_B   = 8'hC7;
    localparam logic [7:0] OP_READ_ADDRESSED_REG_CMD   = 8'h65;
    localparam logic [7:0] OP_WRITE_ADDRESSED_REG_CMD   = 8'h71;
    localparam logic [7:0] OP_SUSP_A = 8'h75;
    localparam logic [7:0] OP_SUSP_B = 8'h85;
    localparam logic [7:0] OP_SUSP_C = 8'hB0;
    localparam logic [7:0] OP_SE     = 8'hD8;
    localparam logic [7:0] OP_RESET  = 8'hF0;

    // Status register one field positions
    localparam int B_STATUS_WRITE_LOCK_COPY  = 7;
    localparam int B_PERR  = 6;
    localparam int B_EERR  = 5;
    localparam int B_BP_HI = 4;
    localparam int B_BP_LO = 2;
    localparam int B_WEL   = 1;
    localparam int B_WIP   = 0;

    // Register addresses seen by the addressed read and write commands
    localparam logic [23:0] ADDR_STATUS_ONE_PERSISTENT = 24'h000000;
    localparam logic [23:0] ADDR_STATUS_ONE_VOLATILE  = 24'h800000;

    localparam logic [4:0] CNT_BYTE_LAST = 5'h07;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h17;
    localparam logic [2:0] BP_CLEAR      = 3'h0;

    typedef enum logic [2:0] {
        PH_CMD  = 3'b000,
        PH_ADDR = 3'b001,
        PH_DATA = 3'b010,
        PH_READ = 3'b011,
        PH_SKIP = 3'b100
    } fsv_ph_t;

    typedef enum logic [2:0] {
        OPK_PROG  = 3'b000,
        OPK_OTP   = 3'b001,
        OPK_SECT  = 3'b010,
        OPK_BULK  = 3'b011,
        OPK_NVREG = 3'b100
    } fsv_opk_t;

    typedef struct packed {
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic       wp1;
        logic       wp2;
        logic       cs_p;
        logic       sck_p;
        fsv_ph_t    ph;
        logic [4:0] cnt;
        logic       go;
        logic       done;
        logic [7:0] opc;
        logic [23:0] addr;
        logic [7:0] data;
        logic [7:0] shreg;
        logic       so;
        logic       so_oe;
        logic       status_write_lock_copy;
        logic       perr;
        logic       eerr;
        logic [2:0] bp_v;
        logic [2:0] prot;
        logic       write_permit_latch;
        logic       operation_busy_flag;
        logic       op_act;
        fsv_opk_t   kind;
        logic       op_req;
        logic       sus_req;
        logic       nv_req;
        logic [7:0] nv_data;
        logic       load_pend;
    } fsv_st_t;

endpackage

// *** hw/fsv_status_one.sv ***
module fsv_status_one
    import fsv_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_si,
    input  wire logic        wp_n,
    input  wire logic [7:0]  nv_status_one,
    input  wire logic        protect_select_volatile,
    input  wire logic [7:0]  status_two,
    input  wire logic        target_protected,
    input  wire logic        otp_region_locked,
    input  wire logic        op_done,
    input  wire logic        op_fail,
    output logic             spi_so,
    output logic             spi_so_oe,
    output logic             op_req,
    output fsv_opk_t         op_kind,
    output logic [23:0]      op_addr,
    output logic             suspend_req,
    output logic             nv_wr_req,
    output logic [7:0]       nv_wr_data,
    output logic [2:0]       active_protect,
    output logic [7:0]       status_one_volatile
);

    fsv_st_t r;
    fsv_st_t n;

    logic cs_s;
    logic sck_s;
    logic si_s;
    logic wp_s;
    logic rise;
    logic fall;
    logic cs_rise;
    logic exec;
    logic locked;
    logic exec_write_permit_cmd;
    logic exec_write_forbid_cmd;
    logic exec_clear_status_cmd;
    logic exec_rst;
    logic exec_be;

    function automatic logic [7:0] stat_byte(input fsv_st_t s);
        stat_byte = {s.status_write_lock_copy, s.perr, s.eerr, s.bp_v, s.write_permit_latch, s.operation_busy_flag};
    endfunction

    function automatic logic busy_ok(input logic [7:0] op);
        busy_ok = (op == OP_READ_STATUS_ONE_CMD) || (op == OP_READ_STATUS_TWO_CMD) || (op == OP_READ_ADDRESSED_REG_CMD)
               || (op == OP_SUSP_A) || (op == OP_SUSP_B)
               || (op == OP_SUSP_C) || (op == OP_CLEAR_STATUS_CMD_A)
               || (op == OP_CLEAR_STATUS_CMD_B) || (op == OP_RESET);
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] op,
                                           input logic [23:0] a,
                                           input logic [7:0] st,
                                           input logic [7:0] sr2,
                                           input logic [7:0] nv);
        if (op == OP_READ_STATUS_TWO_CMD) begin
            rd_byte = sr2;
        end else if (op == OP_READ_ADDRESSED_REG_CMD && a == ADDR_STATUS_ONE_VOLATILE) begin
            rd_byte = st;
        end else if (op == OP_READ_ADDRESSED_REG_CMD && a == ADDR_STATUS_ONE_PERSISTENT) begin
            rd_byte = nv;
        end else if (op == OP_READ_ADDRESSED_REG_CMD) begin
            rd_byte = 8'h00;
        end else begin
            rd_byte = st;
        end
    endfunction

    assign cs_s      = r.sy2[2];
    assign sck_s     = r.sy2[1];
    assign si_s      = r.sy2[0];
    assign wp_s      = r.wp2;
    assign rise      = sck_s && !r.sck_p && !cs_s;
    assign fall      = !sck_s && r.sck_p && !cs_s;
    assign cs_rise   = cs_s && !r.cs_p;
    assign exec      = cs_rise && r.go && r.done;
    assign locked    = nv_status_one[B_STATUS_WRITE_LOCK_COPY] && !wp_s;
    assign exec_write_permit_cmd = exec && r.opc == OP_WRITE_PERMIT_CMD;
    assign exec_write_forbid_cmd = exec && r.opc == OP_WRITE_FORBID_CMD;
    assign exec_clear_status_cmd = exec && (r.opc == OP_CLEAR_STATUS_CMD_A || r.opc == OP_CLEAR_STATUS_CMD_B);
    assign exec_rst  = exec && r.opc == OP_RESET;
    assign exec_be   = exec && (r.opc == OP_BE_A || r.opc == OP_BE_B);

    always_comb begin
        n = r;
        n.sy1     = {spi_cs_n, spi_sck, spi_si};
        n.sy2     = r.sy1;
        n.wp1     = wp_n;
        n.wp2     = r.wp1;
        n.cs_p    = cs_s;
        n.sck_p   = sck_s;
        n.op_req  = 1'h0;
        n.sus_req = 1'h0;
        n.nv_req  = 1'h0;
        n.status_write_lock_copy    = nv_status_one[B_STATUS_WRITE_LOCK_COPY];
        n.prot    = protect_select_volatile ? r.bp_v
                  : nv_status_one[B_BP_HI:B_BP_LO];
        if (r.load_pend) begin
            n.bp_v      = nv_status_one[B_BP_HI:B_BP_LO];
            n.load_pend = 1'h0;
        end
        if (rise) begin
            n.cnt = r.cnt + 5'h01;
            case (r.ph)
                PH_CMD: begin
                    n.opc = {r.opc[6:0], si_s};
                    if (r.cnt == CNT_BYTE_LAST) begin
                        n.cnt = 5'h00;
                        if (r.operation_busy_flag && !busy_ok(n.opc)) begin
                            n.ph = PH_SKIP;
                        end else begin
                            n.go = 1'h1;
                            case (n.opc)
                                OP_READ_STATUS_ONE_CMD, OP_READ_STATUS_TWO_CMD: n.ph = PH_READ;
                                OP_WRR: n.ph = PH_DATA;
                                OP_WRITE_ADDRESSED_REG_CMD, OP_READ_ADDRESSED_REG_CMD, OP_PP, OP_OTPP,
                                OP_SE: n.ph = PH_ADDR;
                                default: begin
                                    n.ph   = PH_SKIP;
                                    n.done = 1'h1;
                                end
                            endcase
                        end
                    end
                end
                PH_ADDR: begin
                    n.addr = {r.addr[22:0], si_s};
                    if (r.cnt == CNT_ADDR_LAST) begin
                        n.cnt = 5'h00;
                        if (r.opc == OP_READ_ADDRESSED_REG_CMD) begin
                            n.ph = PH_READ;
                        end else if (r.opc == OP_WRITE_ADDRESSED_REG_CMD) begin
                            n.ph = PH_DATA;
                        end else begin
                            n.ph   = PH_SKIP;
                            n.done = 1'h1;
                        end
                    end
                end
                PH_DATA: begin
                    n.data = {r.data[6:0], si_s};
                    if (r.cnt == CNT_BYTE_LAST) begin
                        n.ph   = PH_SKIP;
                        n.done = 1'h1;
                    end
                end
                default: n.cnt = r.cnt;
            endcase
        end
        // Status reads repeat; each new byte is a fresh snapshot
        if (fall && r.ph == PH_READ) begin
            n.so_oe = 1'h1;
            n.cnt   = {2'h0, r.cnt[2:0] + 3'h1};
            if (r.cnt[2:0] == 3'h0) begin
                n.shreg = rd_byte(r.opc, r.addr, stat_byte(r),
                                  status_two, nv_status_one);
                n.so    = n.shreg[7];
                n.shreg = {n.shreg[6:0], 1'h0};
            end else begin
                n.so    = r.shreg[7];
                n.shreg = {r.shreg[6:0], 1'h0};
            end
        end
        if (cs_rise) begin
            n.ph    = PH_CMD;
            n.cnt   = 5'h00;
            n.go    = 1'h0;
            n.done  = 1'h0;
            n.so_oe = 1'h0;
        end
        if (exec) begin
            case (r.opc)
                OP_WRITE_PERMIT_CMD: n.write_permit_latch = 1'h1;
                OP_WRITE_FORBID_CMD: n.write_permit_latch = 1'h0;
                OP_CLEAR_STATUS_CMD_A, OP_CLEAR_STATUS_CMD_B: begin
                    n.perr = 1'h0;
                    n.eerr = 1'h0;
                    if (!r.op_act) begin
                        n.operation_busy_flag = 1'h0;
                    end
                end
                OP_RESET: begin
                    n.write_permit_latch       = 1'h0;
                    n.perr      = 1'h0;
                    n.eerr      = 1'h0;
                    n.operation_busy_flag       = 1'h0;
                    n.op_act    = 1'h0;
                    n.load_pend = 1'h1;
                end
                OP_SUSP_A, OP_SUSP_B, OP_SUSP_C: begin
                    if (r.op_act && r.kind != OPK_NVREG) begin
                        n.sus_req = 1'h1;
                    end
                end
                // Volatile write ends at once and drops the latch; a
                // persistent write keeps it until the engine succeeds
                OP_WRR, OP_WRITE_ADDRESSED_REG_CMD: begin
                    if (r.write_permit_latch && !locked) begin
                        if (protect_select_volatile
                            && (r.opc == OP_WRR || r.addr == ADDR_STATUS_ONE_VOLATILE))
                        begin
                            n.bp_v = r.data[B_BP_HI:B_BP_LO];
                            n.write_permit_latch  = 1'h0;
                        end else if (!protect_select_volatile
                            && (r.opc == OP_WRR || r.addr == ADDR_STATUS_ONE_PERSISTENT))
                        begin
                            n.nv_req  = 1'h1;
                            n.nv_data = {r.data[B_STATUS_WRITE_LOCK_COPY],
                                nv_status_one[B_PERR:B_EERR],
                                r.data[B_BP_HI:B_BP_LO],
                                nv_status_one[B_WEL:B_WIP]};
                            n.bp_v    = r.data[B_BP_HI:B_BP_LO];
                            n.op_act  = 1'h1;
                            n.kind    = OPK_NVREG;
                            n.operation_busy_flag     = 1'h1;
                        end
                    end
                end
                OP_PP, OP_OTPP, OP_SE: begin
                    if (r.write_permit_latch) begin
                        if (r.opc == OP_OTPP ? otp_region_locked
                                             : target_protected) begin
                            n.perr = r.opc != OP_SE;
                            n.eerr = r.opc == OP_SE;
                            n.operation_busy_flag  = 1'h1;
                        end else begin
                            n.op_req = 1'h1;
                            n.op_act = 1'h1;
                            n.operation_busy_flag    = 1'h1;
                            n.kind   = r.opc == OP_PP ? OPK_PROG
                                     : r.opc == OP_OTPP ? OPK_OTP
                                     : OPK_SECT;
                        end
                    end
                end
                OP_BE_A, OP_BE_B: begin
                    if (r.write_permit_latch && r.prot == BP_CLEAR) begin
                        n.op_req = 1'h1;
                        n.op_act = 1'h1;
                        n.operation_busy_flag    = 1'h1;
                        n.kind   = OPK_BULK;
                    end
                end
                default: n.go = 1'h0;
            endcase
        end
        // Completion follows the command so an error set wins a clear
        if (op_done && r.op_act && !exec_rst) begin
            n.op_act = 1'h0;
            if (op_fail) begin
                if (r.kind == OPK_SECT || r.kind == OPK_BULK) begin
                    n.eerr = 1'h1;
                end else begin
                    n.perr = 1'h1;
                end
            end else begin
                n.operation_busy_flag = 1'h0;
                n.write_permit_latch = 1'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r           <= '0;
            r.sy1       <= 3'h7;
            r.sy2       <= 3'h7;
            r.cs_p      <= 1'h1;
            r.load_pend <= 1'h1;
        end else begin
            r <= n;
        end
    end

    assign spi_so              = r.so;
    assign spi_so_oe           = r.so_oe;
    assign op_req              = r.op_req;
    assign op_kind             = r.kind;
    assign op_addr             = r.addr;
    assign suspend_req         = r.sus_req;
    assign nv_wr_req           = r.nv_req;
    assign nv_wr_data          = r.nv_data;
    assign active_protect      = r.prot;
    assign status_one_volatile = stat_byte(r);

    a_perr_on_fail: assert property (
        @(posedge clk) disable iff (!rst_n)
        op_done && op_fail && r.op_act && r.kind == OPK_PROG && !exec_rst
        |=> r.perr)
        else $error("program failure did not set error flag");

    a_err_keep: assert property (
        @(posedge clk) disable iff (!rst_n)
        r.perr && !exec_clear_status_cmd && !exec_rst |=> r.perr)
        else $error("program error flag cleared without clear command");

    a_bulk_refuse: assert property (
        @(posedge clk) disable iff (!rst_n)
        exec_be && r.prot != BP_CLEAR && !r.op_act
        |=> !r.op_req && r.eerr == $past(r.eerr))
        else $error("bulk erase ran or flagged under protection");

    a_start_needs_wel: assert property (
        @(posedge clk) disable iff (!rst_n)
        r.op_req || r.nv_req |-> $past(r.write_permit_latch))
        else $error("operation started without write latch");

    a_write_permit_cmd_sets: assert property (
        @(posedge clk) disable iff (!rst_n)
        exec_write_permit_cmd |=> r.write_permit_latch)
        else $error("write permit did not set latch");

    a_write_forbid_cmd_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        exec_write_forbid_cmd |=> !r.write_permit_latch ##1 !r.write_permit_latch)
        else $error("write forbid did not clear latch");

    a_done_clean: assert property (
        @(posedge clk) disable iff (!rst_n)
        op_done && !op_fail && r.op_act && !exec_rst
        |=> !r.operation_busy_flag && !r.write_permit_latch)
        else $error("clean completion left busy or latch set");

    a_busy_op: assert property (
        @(posedge clk) disable iff (!rst_n)
        r.op_act |-> r.operation_busy_flag)
        else $error("operation active while not busy");

    a_err_busy: assert property (
        @(posedge clk) disable iff (!rst_n)
        r.perr || r.eerr |-> r.operation_busy_flag)
        else $error("error flag set while not busy");

    a_busy_block: assert property (
        @(posedge clk) disable iff (!rst_n)
        rise && r.ph == PH_CMD && r.cnt == CNT_BYTE_LAST && r.operation_busy_flag
        && !busy_ok({r.opc[6:0], si_s}) |=> !r.go && r.ph == PH_SKIP)
        else $error("command accepted while busy");

endmodule // fsv_status_one

// *** tb/fsv_host_model.sv ***
module fsv_host_model (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // One command per frame, MSB first, sck rests low (mode 0)
    task automatic xfer(input logic [39:0] tx, input int n, input bit rdn,
                        output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        for (int i = 7; i >= 0 && rdn; i--) begin
            si = ~si;
            #80 sck = 1'b1;
            rx[i] = so;
            #80 sck = 1'b0;
        end
        #80 cs_n = 1'b1;
        // Released line keeps moving so stale bits never pass as data
        si = ~si;
        #80;
    endtask
endmodule // fsv_host_model

// *** tb/fsv_status_one_tb_top.sv ***
module fsv_status_one_tb_top
    import fsv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rst_n;
    logic        spi_sck;
    logic        spi_cs_n;
    logic        spi_si;
    logic        wp_n;
    logic [7:0]  nv_status_one;
    logic        protect_select_volatile;
    logic [7:0]  status_two;
    logic        target_protected;
    logic        otp_region_locked;
    logic        op_done;
    logic        op_fail;
    logic        spi_so;
    logic        spi_so_oe;
    logic        op_req;
    fsv_opk_t    op_kind;
    logic [23:0] op_addr;
    logic        suspend_req;
    logic        nv_wr_req;
    logic [7:0]  nv_wr_data;
    logic [2:0]  active_protect;
    logic [7:0]  status_one_volatile;
    int          fail_count;
    int          n_compared;
    int          n_op;
    int          n_sus;
    int          n_nv;
    fsv_opk_t    kind_seen;
    logic [23:0] addr_seen;
    logic [7:0]  nvd_seen;
    logic [7:0]  rd;

    always #2.5 clk = ~clk;

    fsv_status_one u_fsv_status_one (
        .clk                     (clk),
        .rst_n                   (rst_n),
        .spi_sck                 (spi_sck),
        .spi_cs_n                (spi_cs_n),
        .spi_si                  (spi_si),
        .wp_n                    (wp_n),
        .nv_status_one           (nv_status_one),
        .protect_select_volatile (protect_select_volatile),
        .status_two              (status_two),
        .target_protected        (target_protected),
        .otp_region_locked       (otp_region_locked),
        .op_done                 (op_done),
        .op_fail                 (op_fail),
        .spi_so                  (spi_so),
        .spi_so_oe               (spi_so_oe),
        .op_req                  (op_req),
        .op_kind                 (op_kind),
        .op_addr                 (op_addr),
        .suspend_req             (suspend_req),
        .nv_wr_req               (nv_wr_req),
        .nv_wr_data              (nv_wr_data),
        .active_protect          (active_protect),
        .status_one_volatile     (status_one_volatile)
    );

    fsv_host_model u_fsv_host_model (
        .sck  (spi_sck),
        .cs_n (spi_cs_n),
        .si   (spi_si),
        .so   (spi_so)
    );

    // Pulses stand one cycle, so they are counted as they pass
    always @(posedge clk) begin
        if (op_req === 1'b1) begin
            n_op++;
            kind_seen = op_kind;
            addr_seen = op_addr;
        end
        if (suspend_req === 1'b1) begin
            n_sus++;
        end
        if (nv_wr_req === 1'b1) begin
            n_nv++;
            nvd_seen = nv_wr_data;
        end
    end

    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic st(input logic [7:0] exp);
        chk(status_one_volatile, exp);
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic [39:0] tx, input int n);
        logic [7:0] d;
        u_fsv_host_model.xfer(tx, n, 1'b0, d);
        settle();
    endtask

    task automatic rdb(input logic [39:0] tx, input int n);
        u_fsv_host_model.xfer(tx, n, 1'b1, rd);
        settle();
    endtask

    task automatic engine_end(input logic fail);
        repeat (20) @(posedge clk);
        #1;
        op_done = 1'b1;
        op_fail = fail;
        @(posedge clk);
        #1;
        op_done = 1'b0;
        op_fail = 1'b0;
        settle();
    endtask

    task automatic t_reset();
        st(8'h88);
        rdb(OP_READ_STATUS_ONE_CMD, 8);
        chk(rd, 8'h88);
        chk(spi_so_oe, 1'b0);
        nv_status_one = 8'h08;
        settle();
        st(8'h08);
    endtask

    task automatic t_latch();
        int n0;
        int n1;
        n0 = n_op;
        n1 = n_sus;
        cmd(OP_WRITE_PERMIT_CMD, 8);
        st(8'h0A);
        cmd(OP_WRITE_FORBID_CMD, 8);
        st(8'h08);
        cmd({OP_SE, 24'h123456}, 32);
        cmd(OP_SUSP_C, 8);
        chk(n_op, n0);
        chk(n_sus, n1);
        st(8'h08);
    endtask

    task automatic t_sector();
        int n0;
        n0 = n_op;
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_SE, 24'h123456}, 32);
        chk(n_op, n0 + 1);
        chk(kind_seen, OPK_SECT);
        chk(addr_seen, 24'h123456);
        st(8'h0B);
        cmd(OP_WRITE_FORBID_CMD, 8);
        rdb(OP_READ_STATUS_ONE_CMD, 8);
        chk(rd, 8'h0B);
        status_two = 8'h05;
        rdb(OP_READ_STATUS_TWO_CMD, 8);
        chk(rd, 8'h05);
        engine_end(1'b0);
        st(8'h08);
    endtask

    task automatic t_fail();
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_PP, 24'h000100}, 32);
        chk(kind_seen, OPK_PROG);
        engine_end(1'b1);
        st(8'h4B);
        cmd({OP_WRR, 8'h00}, 16);
        st(8'h4B);
        cmd(OP_CLEAR_STATUS_CMD_A, 8);
        st(8'h0A);
        cmd(OP_WRITE_FORBID_CMD, 8);
        st(8'h08);
    endtask

    task automatic t_prot();
        int n0;
        n0 = n_op;
        target_protected = 1'b1;
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_SE, 24'h000200}, 32);
        st(8'h2B);
        cmd(OP_CLEAR_STATUS_CMD_B, 8);
        st(8'h0A);
        target_protected = 1'b0;
        otp_region_locked = 1'b1;
        cmd({OP_OTPP, 24'h000010}, 32);
        st(8'h4B);
        cmd(OP_CLEAR_STATUS_CMD_A, 8);
        otp_region_locked = 1'b0;
        cmd(OP_BE_A, 8);
        cmd(OP_BE_B, 8);
        chk(n_op, n0);
        st(8'h0A);
        cmd(OP_WRITE_FORBID_CMD, 8);
    endtask

    task automatic t_regw();
        int n2;
        n2 = n_nv;
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_WRR, 8'h14}, 16);
        chk(n_nv, n2 + 1);
        chk(nvd_seen[4:2], 3'h5);
        chk(status_one_volatile[0], 1'b1);
        nv_status_one = 8'h14;
        engine_end(1'b0);
        st(8'h14);
        chk(active_protect, 3'h5);
        protect_select_volatile = 1'b1;
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_WRITE_ADDRESSED_REG_CMD, ADDR_STATUS_ONE_VOLATILE, 8'h0C}, 40);
        chk(n_nv, n2 + 1);
        st(8'h0C);
        chk(active_protect, 3'h3);
        rdb({OP_READ_ADDRESSED_REG_CMD, ADDR_STATUS_ONE_VOLATILE}, 32);
        chk(rd, 8'h0C);
        rdb({OP_READ_ADDRESSED_REG_CMD, ADDR_STATUS_ONE_PERSISTENT}, 32);
        chk(rd, 8'h14);
        rdb({OP_READ_ADDRESSED_REG_CMD, 24'h000123}, 32);
        chk(rd, 8'h00);
    endtask

    task automatic t_lock();
        nv_status_one = 8'h94;
        wp_n = 1'b0;
        settle();
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_WRR, 8'h00}, 16);
        st(8'h8E);
        wp_n = 1'b1;
        cmd({OP_WRR, 8'h00}, 16);
        st(8'h80);
    endtask

    task automatic t_susp();
        int n1;
        n1 = n_sus;
        cmd(OP_WRITE_PERMIT_CMD, 8);
        cmd({OP_PP, 24'h000300}, 32);
        cmd(OP_SUSP_B, 8);
        chk(n_sus, n1 + 1);
        cmd(OP_RESET, 8);
        st(8'h94);
    endtask

    // Hardware reset in mid-run must drop the latch and reload protection
    task automatic t_hwrst();
        cmd(OP_WRITE_PERMIT_CMD, 8);
        st(8'h96);
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        st(8'h00);
        rst_n = 1'b1;
        settle();
        st(8'h94);
    endtask

    initial begin
        #400000;
        fail_count++;
        finish_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wp_n = 1'b1;
        nv_status_one = 8'h88;
        protect_select_volatile = 1'b0;
        status_two = 8'h00;
        target_protected = 1'b0;
        otp_region_locked = 1'b0;
        op_done = 1'b0;
        op_fail = 1'b0;
        fail_count = 0;
        n_compared = 0;
        n_op = 0;
        n_sus = 0;
        n_nv = 0;
        repeat (6) @(posedge clk);
        #1;
        chk(status_one_volatile, 8'h00);
        rst_n = 1'b1;
        settle();
        t_reset();
        t_latch();
        t_sector();
        t_fail();
        t_prot();
        t_regw();
        t_lock();
        t_susp();
        t_hwrst();
        finish_test();
    end
endmodule // fsv_status_one_tb_top
